/* rtl/tpc_defs.svh */
// Offsets, field positions, reset values and timing counts
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

`define TPC_OFF_WAKE_PWR 8'h22
`define TPC_OFF_PLL_CTRL 8'h24
`define TPC_OFF_ACTIVATE 8'h30
`define TPC_OFF_SLOW_CFG 8'hf0
`define TPC_OFF_PIN_FN 8'hf1
`define TPC_OFF_WAKE_EN 8'hf2
`define TPC_OFF_WAKE_ST 8'hf3
`define TPC_OFF_FAN_GPIO 8'hf4

`define TPC_BIT_WAKE_PWR 7
`define TPC_BIT_PLL_CTRL 1
`define TPC_BIT_SLOW_ABSENT 0
`define TPC_BIT_UART2_ACT 0

`define TPC_PF_PIN53_FN 1:0
`define TPC_PF_PIN53_DATA 2
`define TPC_PF_PIN43_DIR 3
`define TPC_PF_PIN43_DATA 4
`define TPC_PF_PIN43_INV 5
`define TPC_PF_PIN43_ALT 6
`define TPC_PF_FAN_EN 7

`define TPC_RST_REG 8'h00

`define TPC_CLK_HZ 40000000
`define TPC_SLOW_HZ 32768
`define TPC_SLOW_DIV (`TPC_CLK_HZ / `TPC_SLOW_HZ)
`define TPC_DIV_W 11

`define TPC_SYNC_W 19

`endif

/* rtl/tpc_div32k.sv */
// Divider making a slow tick from the system clock
`timescale 1ns/1ps
`include "tpc_defs.svh"
module tpc_div32k (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  output logic tick_o
);
  localparam logic [`TPC_DIV_W-1:0] DIV_LAST = `TPC_DIV_W'(`TPC_SLOW_DIV - 1);
  logic [`TPC_DIV_W-1:0] cnt_ff;
  logic tick_ff;
  wire wrap = (cnt_ff == DIV_LAST);

  // Integer divide: tick runs slightly fast, well within the nominal rate
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ce_i) begin
      cnt_ff <= (!run_i || wrap) ? '0 : cnt_ff + `TPC_DIV_W'(1);
      tick_ff <= run_i && wrap;
    end
  end

  assign tick_o = tick_ff;
endmodule // tpc_div32k

/* rtl/tpc_pkg.sv */
// Types shared by the trickle power and clock control block
package tpc_pkg;

  typedef enum logic [1:0] {
    TPC_PIN53_GPIO = 2'b00,
    TPC_PIN53_UART = 2'b01,
    TPC_PIN53_IR = 2'b10
  } tpc_pin53_fn_t;

  typedef struct packed {
    logic p32_pwr;
    logic p32_sel;
    logic p14_pwr;
    logic p14_sel;
  } tpc_pll_t;

  typedef struct packed {
    logic gpio;
    logic fan;
    logic key;
    logic infra;
    logic mouse;
    logic kbd;
    logic ri2;
    logic ri1;
  } tpc_wake_t;

endpackage

/* rtl/tpc_sync2.sv */
// Two flip-flop synchroniser for a group of pin-level inputs
`timescale 1ns/1ps
module tpc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // tpc_sync2

/* rtl/tpc_top.sv */
// Trickle power, PLL select, slow clock and wake control
//
// Contract
// - Host accesses decoded only with supply good
// - Standby wake inputs stay alive without supply
// - Supply good picks infrared clock, timeout
// - Wake-power bit powers slow-clock PLL
// - PLL-control bit powers down every PLL
// - 0,0,1: fast PLL on and selected
// - 0,1,0: slow PLL on and selected
// - 0,1,1: both on, fast selected
// - Wake-power bit affects infrared wake only among wake sources
// - Slow-absent flag at 0xF0 bit 0
// - Slow flag picks external or derived clock
// - Slow-clock wakes need clock on standby
// - Enabled wake sources pull wake output low
// - Main-supplied wake pins input-only on standby
// - Alt infrared receive wakes infrared only
// - Fan pins low after reset, GPIO standby
// - GPIO 53 low after any reset
// - GPIO 43 keeps settings on supply loss
// - GPIO 36, 37, 40 never wake
// - Infrared transmit low until port activated
// - GPIO 53 follows chosen transmit once active
`timescale 1ns/1ps
`include "tpc_defs.svh"
module tpc_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic supply_good_i,
  input wire logic main_por_n_i,
  input wire logic hard_rst_n_i,
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic slow_clock_in_i,
  input wire logic ring_indicator_1_n_i,
  input wire logic ring_indicator_2_n_i,
  input wire logic keyboard_data_line_i,
  input wire logic mouse_data_line_i,
  input wire logic infrared_receive_alt_i,
  input wire logic [1:0] fan_tach_i,
  input wire logic [7:0] gpio_wake_i,
  input wire logic ir_wake_i,
  input wire logic key_wake_i,
  input wire logic ir_tx_i,
  input wire logic uart2_transmit_i,
  input wire logic [1:0] fan_pwm_i,
  input wire logic gpio43_alt_i,
  output logic host_access_en_o,
  output tpc_pkg::tpc_pll_t pll_o,
  output logic ir_hd_timeout_dis_o,
  output logic slow_int_src_o,
  output logic slow_tick_o,
  output logic ir_alt_wake_o,
  output logic wake_event_out_n_o,
  output logic wake_event_oe_o,
  output logic infrared_transmit_alt_o,
  output logic gpio_pin_53_o,
  output logic gpio_pin_53_oe_o,
  output logic [1:0] fan_ctrl_o,
  output logic [1:0] fan_ctrl_oe_o,
  output logic gpio_pin_43_o,
  output logic gpio_pin_43_oe_o
);

  // Pin-level inputs, all through the synchroniser
  logic [`TPC_SYNC_W-1:0] raw_pins;
  logic [`TPC_SYNC_W-1:0] syn_pins;
  assign raw_pins = {supply_good_i, main_por_n_i, hard_rst_n_i,
                     slow_clock_in_i, ring_indicator_1_n_i,
                     ring_indicator_2_n_i, keyboard_data_line_i,
                     mouse_data_line_i, infrared_receive_alt_i,
                     fan_tach_i, gpio_wake_i};

  tpc_sync2 #(
    .W(`TPC_SYNC_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(raw_pins),
    .sync_o(syn_pins)
  );

  wire sg = syn_pins[18];
  wire main_rst = !syn_pins[17] || !syn_pins[16];
  wire slow_in = syn_pins[15];
  wire ri1_n = syn_pins[14];
  wire ri2_n = syn_pins[13];
  wire kbd = syn_pins[12];
  wire mouse = syn_pins[11];
  wire ir_rx_alt = syn_pins[10];
  wire [1:0] tach = syn_pins[9:8];
  wire [7:0] gpio_in = syn_pins[7:0];

  // Standby-domain registers, cleared by standby POR only
  logic [7:0] wake_pwr_reg_ff;
  logic [7:0] pll_ctrl_reg_ff;
  logic [7:0] activate_ff;
  logic [7:0] slow_cfg_ff;
  logic [7:0] wake_en_ff;
  logic [7:0] wake_st_ff;
  logic [7:0] fan_gpio_ff;
  // Main-domain registers, also cleared by main POR or hard reset
  logic [7:0] pin_fn_ff;
  logic tx_armed_ff;

  // Previous samples for edge detection
  logic kbd_q_ff;
  logic mouse_q_ff;
  logic [1:0] tach_q_ff;
  logic [7:0] gpio_q_ff;
  logic slow_q_ff;

  wire acc = reg_sel_i && sg;
  wire wr = acc && reg_wr_i;
  wire rd = acc && !reg_wr_i;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire wr_wpwr = wr && hit(reg_addr_i, `TPC_OFF_WAKE_PWR);
  wire wr_pllc = wr && hit(reg_addr_i, `TPC_OFF_PLL_CTRL);
  wire wr_act = wr && hit(reg_addr_i, `TPC_OFF_ACTIVATE);
  wire wr_slow = wr && hit(reg_addr_i, `TPC_OFF_SLOW_CFG);
  wire wr_pfn = wr && hit(reg_addr_i, `TPC_OFF_PIN_FN);
  wire wr_wen = wr && hit(reg_addr_i, `TPC_OFF_WAKE_EN);
  wire wr_wst = wr && hit(reg_addr_i, `TPC_OFF_WAKE_ST);
  wire wr_fgp = wr && hit(reg_addr_i, `TPC_OFF_FAN_GPIO);

  wire wake_pwr = wake_pwr_reg_ff[`TPC_BIT_WAKE_PWR];
  wire pll_ctrl = pll_ctrl_reg_ff[`TPC_BIT_PLL_CTRL];
  wire slow_absent = slow_cfg_ff[`TPC_BIT_SLOW_ABSENT];
  wire uart2_act = activate_ff[`TPC_BIT_UART2_ACT];
  wire [1:0] pin53_fn = pin_fn_ff[`TPC_PF_PIN53_FN];

  // PLL power and select table
  tpc_pkg::tpc_pll_t nxt_pll;
  always_comb begin
    nxt_pll = '0;
    if (pll_ctrl) begin
      nxt_pll = '0;
    end else begin
      nxt_pll.p32_pwr = wake_pwr;
      nxt_pll.p14_pwr = sg;
      nxt_pll.p14_sel = sg;
      nxt_pll.p32_sel = wake_pwr && !sg;
    end
  end

  logic int_tick;
  tpc_div32k u_div (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(slow_absent && sg),
    .tick_o(int_tick)
  );
  wire ext_tick = slow_in && !slow_q_ff;
  wire nxt_slow_tick = slow_absent ? int_tick : ext_tick;

  // slow-clock wakes need a running clock
  wire slow_ok = sg || !slow_absent;
  wire ir_ok = sg || (wake_pwr && slow_ok);

  tpc_pkg::tpc_wake_t wev;
  always_comb begin
    wev.ri1 = !ri1_n;
    wev.ri2 = !ri2_n;
    wev.kbd = kbd_q_ff && !kbd;
    wev.mouse = mouse_q_ff && !mouse;
    // alt infrared receive into infrared wake only
    wev.infra = ir_ok && (ir_wake_i || (ir_rx_alt != ir_alt_wake_o));
    wev.key = slow_ok && key_wake_i;
    wev.fan = slow_ok && |(tach & ~tach_q_ff);
    // only wake-capable inputs feed this group
    wev.gpio = |(gpio_in ^ gpio_q_ff);
  end

  // Set wins over software clear
  wire [7:0] wst_clr = wr_wst ? reg_wdata_i : 8'h00;
  wire [7:0] nxt_wake_st = (wake_st_ff & ~wst_clr) | (wev & wake_en_ff);
  wire nxt_pend = |(nxt_wake_st & wake_en_ff);

  // Pin drive
  logic nxt_ir_tx_alt;
  logic nxt_pin53;
  logic [1:0] nxt_fan;
  logic nxt_pin43;
  logic nxt_pin43_oe;
  always_comb begin
    // infrared transmit held low until armed
    nxt_ir_tx_alt = sg && tx_armed_ff && ir_tx_i;
    // GPIO 53 low unless function active
    nxt_pin53 = 1'b0;
    if (sg) begin
      unique case (pin53_fn)
        tpc_pkg::TPC_PIN53_GPIO: nxt_pin53 = pin_fn_ff[`TPC_PF_PIN53_DATA];
        tpc_pkg::TPC_PIN53_UART: nxt_pin53 = tx_armed_ff && uart2_transmit_i;
        tpc_pkg::TPC_PIN53_IR: nxt_pin53 = tx_armed_ff && ir_tx_i;
        default: nxt_pin53 = 1'b0;
      endcase
    end
    // fan pins low unless fan enable set, GPIO data on standby
    if (!sg) begin
      nxt_fan = fan_gpio_ff[1:0];
    end else if (pin_fn_ff[`TPC_PF_FAN_EN]) begin
      nxt_fan = fan_pwm_i;
    end else begin
      nxt_fan = 2'b00;
    end
    // GPIO 43 basic function on standby
    if (sg && pin_fn_ff[`TPC_PF_PIN43_ALT]) begin
      nxt_pin43 = gpio43_alt_i;
      nxt_pin43_oe = 1'b1;
    end else begin
      nxt_pin43 = pin_fn_ff[`TPC_PF_PIN43_DATA] ^ pin_fn_ff[`TPC_PF_PIN43_INV];
      nxt_pin43_oe = sg && pin_fn_ff[`TPC_PF_PIN43_DIR];
    end
  end

  // Read mux, unmapped reads as zero
  logic [7:0] nxt_rdata;
  always_comb begin
    unique case (reg_addr_i)
      `TPC_OFF_WAKE_PWR: nxt_rdata = wake_pwr_reg_ff;
      `TPC_OFF_PLL_CTRL: nxt_rdata = pll_ctrl_reg_ff;
      `TPC_OFF_ACTIVATE: nxt_rdata = activate_ff;
      `TPC_OFF_SLOW_CFG: nxt_rdata = slow_cfg_ff;
      `TPC_OFF_PIN_FN: nxt_rdata = pin_fn_ff;
      `TPC_OFF_WAKE_EN: nxt_rdata = wake_en_ff;
      `TPC_OFF_WAKE_ST: nxt_rdata = wake_st_ff;
      `TPC_OFF_FAN_GPIO: nxt_rdata = fan_gpio_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Standby-domain state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_pwr_reg_ff <= `TPC_RST_REG;
      pll_ctrl_reg_ff <= `TPC_RST_REG;
      activate_ff <= `TPC_RST_REG;
      slow_cfg_ff <= `TPC_RST_REG;
      wake_en_ff <= `TPC_RST_REG;
      wake_st_ff <= `TPC_RST_REG;
      fan_gpio_ff <= `TPC_RST_REG;
    end else if (ce_i) begin
      if (wr_wpwr) wake_pwr_reg_ff <= reg_wdata_i;
      if (wr_pllc) pll_ctrl_reg_ff <= reg_wdata_i;
      if (wr_act) activate_ff <= reg_wdata_i;
      if (wr_slow) slow_cfg_ff <= reg_wdata_i;
      // software may drop tach enables here
      if (wr_wen) wake_en_ff <= reg_wdata_i;
      if (wr_fgp) fan_gpio_ff <= reg_wdata_i;
      wake_st_ff <= nxt_wake_st;
    end
  end

  // Main-domain state; main reset is a synchronised level
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_fn_ff <= `TPC_RST_REG;
      tx_armed_ff <= 1'b0;
    end else if (ce_i) begin
      if (main_rst) begin
        pin_fn_ff <= `TPC_RST_REG;
        tx_armed_ff <= 1'b0;
      end else begin
        if (wr_pfn) pin_fn_ff <= reg_wdata_i;
        if (wr_act && reg_wdata_i[`TPC_BIT_UART2_ACT]) tx_armed_ff <= 1'b1;
      end
    end
  end

  // Edge history
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kbd_q_ff <= 1'b0;
      mouse_q_ff <= 1'b0;
      tach_q_ff <= 2'b00;
      gpio_q_ff <= 8'h00;
      slow_q_ff <= 1'b0;
      ir_alt_wake_o <= 1'b0;
    end else if (ce_i) begin
      kbd_q_ff <= kbd;
      mouse_q_ff <= mouse;
      tach_q_ff <= tach;
      gpio_q_ff <= gpio_in;
      slow_q_ff <= slow_in;
      ir_alt_wake_o <= ir_rx_alt;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
      host_access_en_o <= 1'b0;
      pll_o <= '0;
      ir_hd_timeout_dis_o <= 1'b1;
      slow_int_src_o <= 1'b0;
      slow_tick_o <= 1'b0;
      wake_event_out_n_o <= 1'b1;
      wake_event_oe_o <= 1'b0;
      infrared_transmit_alt_o <= 1'b0;
      gpio_pin_53_o <= 1'b0;
      gpio_pin_53_oe_o <= 1'b1;
      fan_ctrl_o <= 2'b00;
      fan_ctrl_oe_o <= 2'b11;
      gpio_pin_43_o <= 1'b0;
      gpio_pin_43_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (rd) reg_rdata_o <= nxt_rdata;
      host_access_en_o <= sg;
      pll_o <= nxt_pll;
      ir_hd_timeout_dis_o <= !sg;
      slow_int_src_o <= slow_absent;
      slow_tick_o <= nxt_slow_tick;
      wake_event_out_n_o <= !nxt_pend;
      wake_event_oe_o <= nxt_pend;
      infrared_transmit_alt_o <= nxt_ir_tx_alt;
      gpio_pin_53_o <= nxt_pin53;
      gpio_pin_53_oe_o <= 1'b1;
      fan_ctrl_o <= nxt_fan;
      fan_ctrl_oe_o <= 2'b11;
      gpio_pin_43_o <= nxt_pin43;
      gpio_pin_43_oe_o <= nxt_pin43_oe;
    end
  end

endmodule // tpc_top

/* verif/test_trickle_power_clock_control.sv */
// Self-checking bench for the trickle power control block
`timescale 1ns/1ps
module test_trickle_power_clock_control;
  logic clk = 1'b0, rst_n = 1'b0, sg = 1'b1, mpor = 1'b1, hrst = 1'b1;
  logic sel = 1'b0, wr = 1'b0, ri1 = 1'b1, ri2 = 1'b1, kbd = 1'b1, mou = 1'b1;
  logic irx = 1'b0, infrared_transmit = 1'b0, utx = 1'b0, cirw = 1'b0, keyw = 1'b0, sck = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, gpw = 8'h00, rdata, d, hits;
  logic [1:0] tach = 2'b00, pwm = 2'b00, fan;
  logic hen, tdis, sint, tick, wn, woe, irt, g53, line_n, g43, g43oe, iraw;
  tpc_pkg::tpc_pll_t pll;
  int n_errors = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  tpc_top dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .supply_good_i(sg),
    .main_por_n_i(mpor), .hard_rst_n_i(hrst), .reg_sel_i(sel), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdata), .slow_clock_in_i(sck),
    .ring_indicator_1_n_i(ri1), .ring_indicator_2_n_i(ri2), .keyboard_data_line_i(kbd),
    .mouse_data_line_i(mou), .infrared_receive_alt_i(irx), .fan_tach_i(tach),
    .gpio_wake_i(gpw), .ir_wake_i(cirw), .key_wake_i(keyw), .ir_tx_i(infrared_transmit),
    .uart2_transmit_i(utx), .fan_pwm_i(pwm), .gpio43_alt_i(1'b0), .host_access_en_o(hen),
    .pll_o(pll), .ir_hd_timeout_dis_o(tdis), .slow_int_src_o(sint), .slow_tick_o(tick),
    .ir_alt_wake_o(iraw), .wake_event_out_n_o(wn), .wake_event_oe_o(woe),
    .infrared_transmit_alt_o(irt), .gpio_pin_53_o(g53), .gpio_pin_53_oe_o(),
    .fan_ctrl_o(fan), .fan_ctrl_oe_o(), .gpio_pin_43_o(g43), .gpio_pin_43_oe_o(g43oe));
  tpc_pme_sink pme_u (.clk_sys_i(clk), .wake_n_i(wn), .wake_oe_i(woe), .line_n_o(line_n),
    .hits_o(hits));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One access; read data lands in d one cycle after the strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wdat <= v;
    @(posedge clk);
    sel <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic wait_line(input logic lvl);
    for (int i = 0; i < 20 && line_n !== lvl; i++) @(posedge clk);
    chk({7'h0, line_n}, {7'h0, lvl});
    if (line_n !== lvl) close_out();
  endtask
  // Bounded wait for a slow tick; a missing tick ends the run
  task automatic wait_tick(input int n);
    for (int i = 0; i < n && tick !== 1'b1; i++) @(posedge clk);
    chk({7'h0, tick}, 8'h01);
    if (tick !== 1'b1) close_out();
  endtask
  function automatic logic [3:0] exp_pll(input logic [2:0] c);
    if (c[2]) return 4'h0;
    case (c[1:0])
      2'b01: return 4'b0011;
      2'b10: return 4'b1100;
      2'b11: return 4'b1011;
      default: return 4'b0000;
    endcase
  endfunction

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    cyc(2);
    chk({hen, tdis, wn, woe, pll}, 8'h60);
    cyc(1);
    rst_n <= 1'b1;
    cyc(4);
    acc(1'b0, 8'hf0, 8'h00);
    chk(d, 8'h00);
    $display("reset test done");
    sg <= 1'b0;
    cyc(4);
    acc(1'b1, 8'hf0, 8'h01);
    sg <= 1'b1;
    cyc(4);
    acc(1'b0, 8'hf0, 8'h00);
    chk(d, 8'h00);
    acc(1'b1, 8'hf0, 8'h01);
    acc(1'b0, 8'hf0, 8'h00);
    chk(d, 8'h01);
    chk({7'h0, sint}, 8'h01);
    wait_tick(1300);
    acc(1'b0, 8'h5a, 8'h00);
    chk(d, 8'h00);
    acc(1'b1, 8'hf0, 8'h00);
    sck <= 1'b1;
    wait_tick(10);
    chk({7'h0, sint}, 8'h00);
    sck <= 1'b0;
    $display("access test done");
    for (int i = 0; i < 8; i++) begin
      sg <= 1'b1;
      cyc(4);
      acc(1'b1, 8'h24, {6'h0, i[2], 1'b0});
      acc(1'b1, 8'h22, {i[1], 7'h0});
      sg <= i[0];
      cyc(6);
      chk({4'h0, pll}, {4'h0, exp_pll(i[2:0])});
      chk({6'h0, tdis, hen}, {6'h0, ~i[0], i[0]});
    end
    sg <= 1'b1;
    cyc(4);
    acc(1'b1, 8'h24, 8'h00);
    $display("clock select test done");
    acc(1'b1, 8'hf2, 8'h01);
    ri2 <= 1'b0;
    kbd <= 1'b0;
    mou <= 1'b0;
    irx <= 1'b1;
    tach <= 2'b11;
    gpw <= 8'hff;
    cirw <= 1'b1;
    keyw <= 1'b1;
    cyc(8);
    chk({7'h0, line_n}, 8'h01);
    ri1 <= 1'b0;
    wait_line(1'b0);
    acc(1'b0, 8'hf3, 8'h00);
    chk(d, 8'h01);
    ri1 <= 1'b1;
    cyc(3);
    acc(1'b1, 8'hf3, 8'h01);
    wait_line(1'b1);
    sg <= 1'b0;
    cyc(4);
    ri1 <= 1'b0;
    wait_line(1'b0);
    ri1 <= 1'b1;
    sg <= 1'b1;
    cyc(4);
    acc(1'b1, 8'hf2, 8'h00);
    acc(1'b1, 8'hf3, 8'hff);
    wait_line(1'b1);
    chk(hits, 8'h02);
    cirw <= 1'b0;
    keyw <= 1'b0;
    acc(1'b1, 8'hf2, 8'h90);
    irx <= 1'b0;
    wait_line(1'b0);
    chk({7'h0, iraw}, 8'h00);
    acc(1'b0, 8'hf3, 8'h00);
    chk(d, 8'h10);
    acc(1'b1, 8'hf2, 8'h20);
    acc(1'b1, 8'hf3, 8'hff);
    acc(1'b1, 8'hf0, 8'h01);
    sg <= 1'b0;
    cyc(4);
    keyw <= 1'b1;
    cyc(8);
    chk({7'h0, line_n}, 8'h01);
    sg <= 1'b1;
    wait_line(1'b0);
    keyw <= 1'b0;
    acc(1'b1, 8'hf2, 8'h00);
    acc(1'b1, 8'hf3, 8'hff);
    acc(1'b1, 8'hf0, 8'h00);
    wait_line(1'b1);
    chk(hits, 8'h04);
    $display("wake test done");
    infrared_transmit <= 1'b1;
    utx <= 1'b1;
    pwm <= 2'b11;
    acc(1'b1, 8'h30, 8'h01);
    acc(1'b1, 8'hf1, 8'h82);
    cyc(2);
    chk({4'h0, irt, g53, fan}, 8'h0f);
    mpor <= 1'b0;
    cyc(6);
    mpor <= 1'b1;
    cyc(4);
    chk({4'h0, irt, g53, fan}, 8'h00);
    acc(1'b1, 8'h30, 8'h01);
    cyc(2);
    chk({7'h0, irt}, 8'h01);
    acc(1'b1, 8'hf1, 8'h82);
    cyc(2);
    chk({5'h0, g53, fan}, 8'h07);
    infrared_transmit <= 1'b0;
    acc(1'b1, 8'hf1, 8'h81);
    cyc(2);
    chk({7'h0, g53}, 8'h01);
    utx <= 1'b0;
    cyc(3);
    chk({7'h0, g53}, 8'h00);
    hrst <= 1'b0;
    cyc(6);
    hrst <= 1'b1;
    cyc(4);
    chk({5'h0, g53, fan}, 8'h00);
    acc(1'b1, 8'hf1, 8'h68);
    cyc(2);
    chk({6'h0, g43, g43oe}, 8'h01);
    acc(1'b1, 8'hf4, 8'h02);
    sg <= 1'b0;
    cyc(6);
    chk({6'h0, fan}, 8'h02);
    chk({6'h0, g43, g43oe}, 8'h02);
    $display("pin test done");
    close_out();
  end
endmodule // test_trickle_power_clock_control

/* verif/tpc_checker.sv */
// Port checker for the trickle power control block
`timescale 1ns/1ps
module tpc_checker (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic main_por_n_i,
  input wire logic reg_sel_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic host_access_en_o,
  input wire tpc_pkg::tpc_pll_t pll_o,
  input wire logic ir_hd_timeout_dis_o,
  input wire logic slow_tick_o,
  input wire logic wake_event_out_n_o,
  input wire logic wake_event_oe_o,
  input wire logic infrared_transmit_alt_o,
  input wire logic gpio_pin_53_o,
  input wire logic [1:0] fan_ctrl_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  a_rdata_hold: assert property (!reg_sel_i |=> $stable(reg_rdata_o))
    else $error("read data moved without an access");
  a_one_sel: assert property (!(pll_o.p32_sel && pll_o.p14_sel))
    else $error("both clocks selected");
  a_slow_sel: assert property (pll_o.p32_sel |-> pll_o.p32_pwr && !pll_o.p14_pwr)
    else $error("slow select with wrong power");
  a_fast_supply: assert property (pll_o.p14_pwr |-> pll_o.p14_sel && host_access_en_o)
    else $error("fast clock powered without supply");
  a_timeout_dis: assert property (ir_hd_timeout_dis_o == !host_access_en_o)
    else $error("timeout disable not tied to supply");
  a_wake_drain: assert property (wake_event_oe_o == !wake_event_out_n_o)
    else $error("wake line not open drain");
  a_gpio_pin_53_standby: assert property (!host_access_en_o [*2] |-> !gpio_pin_53_o)
    else $error("gpio 53 high on standby");
  a_tick_pulse: assert property (slow_tick_o |=> !slow_tick_o)
    else $error("slow tick wider than one cycle");
  a_main_clear: assert property ((host_access_en_o && !main_por_n_i) [*6] |->
    fan_ctrl_o == 2'b00 && !gpio_pin_53_o && !infrared_transmit_alt_o)
    else $error("pins not low in main reset");
  c_wake: cover property (!wake_event_out_n_o);
  c_tick: cover property (slow_tick_o);
  c_slow_sel: cover property (pll_o.p32_sel);
endmodule // tpc_checker

bind tpc_top tpc_checker u_chk (.*);

/* verif/tpc_pme_sink.sv */
// Chipset side of the open-drain wake line
`timescale 1ns/1ps
module tpc_pme_sink (
  input wire logic clk_sys_i,
  input wire logic wake_n_i,
  input wire logic wake_oe_i,
  output logic line_n_o,
  output logic [7:0] hits_o
);
  logic prev = 1'b1;
  logic [7:0] cnt = 8'h00;
  assign line_n_o = wake_oe_i ? wake_n_i : 1'b1;
  // Counts falling edges only, so a held request counts once
  always @(posedge clk_sys_i) begin
    if (prev && !line_n_o) cnt <= cnt + 8'h01;
    prev <= line_n_o;
  end
  assign hits_o = cnt;
endmodule // tpc_pme_sink
